// [logic/fmpc_host.sv]
// Host controller that drives the flash bus for identification and reset.
`timescale 1ns/1ps
// Notes on behaviour
// - HV identification raises the address-nine detect line.
// - Reset-pin HV detect gives temporary unprotect.
// - Write only with select, write low, output high.
// - Leave identification by writing reset.
// - Time-limit flag is only reported on o_time_limit; the host does not write reset itself.
module fmpc_host
  import fmpc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [1:0] i_op,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [DATA_W-1:0] i_dq_in,
  output logic o_busy,
  output logic o_done,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_parity_ok,
  output logic o_time_limit,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_dq_out,
  output logic o_dq_oe_n,
  output logic o_a9_hv,
  output logic o_reset_hv
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_WSETUP, ST_WSTROBE, ST_WHOLD, ST_RSTROBE, ST_RDONE
  } fmpc_state_e;

  fmpc_state_e state_r, state_nxt;
  logic [3:0] cnt_r;
  logic [1:0] step_r;
  logic [1:0] op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic ce_n_r, we_n_r, oe_n_r, dq_oe_n_r, busy_r, done_r, a9_r;
  logic [ADDR_W-1:0] bus_addr_r;
  logic [DATA_W-1:0] dq_r, rdata_r;
  logic par_r, tl_r;

  wire cnt_end = (cnt_r == ONE_CNT);
  wire is_read_op = (op_r == FMPC_OP_READ_ID) || (op_r == FMPC_OP_HV_ID);
  // In idle the request fields feed the bus directly, so the first cycle
  // of a transfer already shows the new address, data and address-nine detect.
  wire in_idle = (state_r == ST_IDLE);
  wire [1:0] op_cur = in_idle ? i_op : op_r;
  wire [ADDR_W-1:0] addr_cur = in_idle ? i_addr : addr_r;
  wire [DATA_W-1:0] wdata_cur = in_idle ? i_wdata : wdata_r;
  wire [1:0] step_cur = in_idle ? 2'd0 : step_r;
  // Marks the last write cycle: the third of an in-system identification, the only one otherwise.
  wire last_write = (op_r == FMPC_OP_READ_ID) ? (step_r == 2'd2) : 1'b1;
  wire [10:0] unlock_a = (step_cur == 2'd1) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
  wire [DATA_W-1:0] unlock_d = (step_cur == 2'd0) ? UNLOCK_DATA1 :
                               (step_cur == 2'd1) ? UNLOCK_DATA2 : CMD_AUTOSEL;
  // The reset command goes out at the caller's address, any value.
  wire [ADDR_W-1:0] w_addr = (op_cur == FMPC_OP_READ_ID) ?
      {{(ADDR_W-11){1'b0}}, unlock_a} : addr_cur;
  wire [DATA_W-1:0] w_data = (op_cur == FMPC_OP_RESET) ? CMD_RESET :
      (op_cur == FMPC_OP_READ_ID) ? unlock_d : wdata_cur;
  wire hv_read = (op_cur == FMPC_OP_HV_ID);
  // Unprotect drops together with busy, so it never outlives the write op.
  wire unprot_on = busy_r && (op_r == FMPC_OP_WRITE) && (state_r != ST_RDONE);
  wire parity_odd = ^i_dq_in;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (i_req) begin
          state_nxt = (i_op == FMPC_OP_HV_ID) ? ST_RSTROBE : ST_WSETUP;
        end
      end
      ST_WSETUP: begin
        if (cnt_end) begin
          state_nxt = ST_WSTROBE;
        end
      end
      ST_WSTROBE: begin
        if (cnt_end) begin
          state_nxt = ST_WHOLD;
        end
      end
      ST_WHOLD: begin
        if (cnt_end) begin
          if (!last_write) state_nxt = ST_WSETUP;
          else if (is_read_op) state_nxt = ST_RSTROBE;
          else state_nxt = ST_RDONE;
        end
      end
      ST_RSTROBE: begin
        if (cnt_end) begin
          state_nxt = ST_RDONE;
        end
      end
      ST_RDONE: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      // Strobes rest high from reset so no write can form.
      state_r <= ST_IDLE;
      cnt_r <= ZERO_CNT;
      step_r <= 2'd0;
      op_r <= FMPC_OP_READ_ID;
      addr_r <= '0;
      wdata_r <= '0;
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      dq_oe_n_r <= 1'b1;
      bus_addr_r <= '0;
      dq_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
      par_r <= 1'b0;
      tl_r <= 1'b0;
      a9_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r <= 1'b0;
      cnt_r <= (state_nxt != state_r) ? PHASE_CYC : cnt_r - ONE_CNT;
      if (state_r == ST_IDLE && i_req) begin
        op_r <= i_op;
        addr_r <= i_addr;
        wdata_r <= i_wdata;
        step_r <= 2'd0;
        busy_r <= 1'b1;
      end
      unique case (state_nxt)
        ST_WSETUP: begin
          // Address and data settle before both strobes fall.
          bus_addr_r <= w_addr;
          dq_r <= w_data;
          dq_oe_n_r <= 1'b0;
          oe_n_r <= 1'b1;
        end
        ST_WSTROBE: begin
          ce_n_r <= 1'b0;
          we_n_r <= 1'b0;
        end
        ST_WHOLD: begin
          ce_n_r <= 1'b1;
          we_n_r <= 1'b1; // Data held through the rising edge.
        end
        ST_RSTROBE: begin
          // Caller's address selects code or group.
          bus_addr_r <= addr_cur;
          dq_oe_n_r <= 1'b1;
          ce_n_r <= 1'b0;
          oe_n_r <= 1'b0; // Output low blocks any write.
          a9_r <= hv_read;
        end
        default: begin
          ce_n_r <= 1'b1;
          we_n_r <= 1'b1;
          oe_n_r <= 1'b1;
        end
      endcase
      if (state_r == ST_WHOLD && cnt_end) step_r <= step_r + 2'd1;
      if (state_r == ST_RSTROBE && cnt_end) begin
        rdata_r <= i_dq_in;
        par_r <= parity_odd;
        tl_r <= i_dq_in[TIME_LIMIT_BIT];
      end
      if (state_r == ST_RDONE) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        dq_oe_n_r <= 1'b1;
        a9_r <= 1'b0;
      end
    end
  end

  // Temporary unprotect is a plain level raised for every write op.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_reset_hv <= 1'b0;
    end else begin
      o_reset_hv <= unprot_on;
    end
  end

  assign o_busy = busy_r;
  assign o_done = done_r;
  assign o_rdata = rdata_r;
  assign o_parity_ok = par_r;
  assign o_time_limit = tl_r;
  assign o_ce_n = ce_n_r;
  assign o_we_n = we_n_r;
  assign o_oe_n = oe_n_r;
  assign o_addr = bus_addr_r;
  assign o_dq_out = dq_r;
  assign o_dq_oe_n = dq_oe_n_r;
  assign o_a9_hv = a9_r;
endmodule

// [logic/fmpc_pkg.sv]
// Constants and types shared by the flash mode-control host.
package fmpc_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;
  localparam int GRP_W = 4;
  localparam int GRP_LSB = 18;
  // Low address byte values for the command-entered readout.
  localparam logic [7:0] ID_OFS_MAKER = 8'h00;
  localparam logic [7:0] ID_OFS_PART = 8'h01;
  localparam logic [7:0] ID_OFS_PROT = 8'h02;
  // Command bytes and unlock addresses are not given; values are arbitrary.
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2aa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] PROT_SET = 8'h01;
  localparam int TIME_LIMIT_BIT = 5;
  localparam int PARITY_BIT = 7;
  // Bus timing: each strobe phase lasts this long.
  localparam int PHASE_NS = 80;
  localparam int CLK_NS = 10;
  localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ZERO_CNT = 4'h0;
  localparam logic [3:0] ONE_CNT = 4'h1;
  typedef enum logic [1:0] {
    FMPC_OP_READ_ID,
    FMPC_OP_HV_ID,
    FMPC_OP_RESET,
    FMPC_OP_WRITE
  } fmpc_op_e;
endpackage

// [tb/fmpc_host_sva.sv]
// Strobe and handshake assertions for the flash host.
`timescale 1ns/1ps
module fmpc_host_sva
  import fmpc_pkg::*;
(
  input logic i_core_clk,
  input logic i_rst_n,
  input logic i_req,
  input logic o_busy,
  input logic o_done,
  input logic o_ce_n,
  input logic o_we_n,
  input logic o_oe_n,
  input logic o_dq_oe_n,
  input logic o_a9_hv,
  input logic [ADDR_W-1:0] o_addr,
  input logic [DATA_W-1:0] o_dq_out,
  input logic o_reset_hv
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_write_gate: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
    else $error("gate");
  a_no_fight: assert property (!o_oe_n |-> o_dq_oe_n)
    else $error("fight");
  a_we_width: assert property ($fell(o_we_n) |-> !o_we_n[*5])
    else $error("width");
  a_unprot_busy: assert property (o_reset_hv |-> o_busy)
    else $error("unprot");
  a_done_pulse: assert property (o_done |=> !o_done) else $error("pulse");
  a_req_taken: assert property (i_req && !o_busy && !o_done |=> o_busy)
    else $error("lost");
  a_op_bound: assert property ($rose(o_busy) |-> ##[8:120] o_done)
    else $error("slow");
  a_idle_quiet: assert property (!o_busy && !o_done |-> o_we_n && o_oe_n)
    else $error("idle");
  a_addr_hold: assert property (!o_we_n |=> $stable(o_addr) && $stable(o_dq_out))
    else $error("address or data moved while the write strobe was low");
  a_hv_no_write: assert property (o_a9_hv |-> o_we_n)
    else $error("write strobe low while the address-nine detect is high");
endmodule
bind fmpc_host fmpc_host_sva u_sva (.*);

// [tb/fmpc_flash_model.sv]
// Behavioural flash device for identification and commands.
`timescale 1ns/1ps
module fmpc_flash_model
  import fmpc_pkg::*;
(
  input logic i_ce_n,
  input logic i_we_n,
  input logic i_oe_n,
  input logic i_a9_hv,
  input logic i_reset_hv,
  input logic [ADDR_W-1:0] i_addr,
  input logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_q
);
  // Identifier codes are arbitrary, each of odd parity.
  localparam logic [7:0] MAKER_CODE = 8'h07;
  localparam logic [7:0] PART_CODE = 8'h2a;
  localparam logic [15:0] PROT_MAP = 16'h0008;
  logic [1:0] step = 2'h0;
  logic id_mode = 1'b0;
  logic unprot = 1'b0;
  logic refused = 1'b0;
  logic [7:0] held = 8'h0;
  wire wr = !i_ce_n && !i_we_n && i_oe_n;
  wire [7:0] idv = i_addr[1] ? {7'h0, PROT_MAP[i_addr[21:18]]}
    : i_addr[0] ? PART_CODE : MAKER_CODE;
  // A released bus shows the inverse of the last byte driven.
  assign o_q = (i_ce_n || i_oe_n) ? ~held
    : (id_mode || i_a9_hv) ? idv : ~i_addr[7:0];
  always @(o_q) if (!i_ce_n && !i_oe_n) held = o_q;
  always @(negedge wr) begin
    // Unprotect is sampled from the reset-pin detect at each write and held until the next.
    unprot = (i_reset_hv === 1'b1);
    // A write into a protected group is refused unless unprotected.
    refused = PROT_MAP[i_addr[21:18]] && !unprot;
    if (step == 2'h0 && i_dq == UNLOCK_DATA1) step = 2'h1;
    else if (step == 2'h1 && i_dq == UNLOCK_DATA2) step = 2'h2;
    else begin
      id_mode = step == 2'h2 && i_dq == CMD_AUTOSEL;
      step = 2'h0;
    end
  end
endmodule

// [tb/fmpc_host_tb.sv]
// Bench driving the flash host against the device model.
`timescale 1ns/1ps
module fmpc_host_tb;
  import fmpc_pkg::*;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_req = 1'b0;
  logic [1:0] i_op = 2'h0;
  logic [ADDR_W-1:0] i_addr = 22'h0, o_addr;
  logic [DATA_W-1:0] i_wdata = 8'h0, i_dq_in, o_rdata, o_dq_out, q;
  logic o_busy, o_done, o_parity_ok, o_time_limit, o_ce_n, o_we_n, o_oe_n;
  logic o_dq_oe_n, o_a9_hv, o_reset_hv;
  int n_mismatch = 0, checked = 0;
  assign i_dq_in = o_dq_oe_n ? q : o_dq_out;
  fmpc_host dut (.*);
  fmpc_flash_model dev (.i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
    .i_a9_hv(o_a9_hv), .i_reset_hv(o_reset_hv), .i_addr(o_addr),
    .i_dq(i_dq_in), .o_q(q));
  initial forever #5 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) n_mismatch++;
    if (got !== exp) $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input logic [1:0] o, input logic [21:0] a);
    @(posedge i_core_clk);
    {i_req, i_op, i_addr, i_wdata} <= {1'b1, o, a, a[7:0]};
    @(posedge i_core_clk);
    i_req <= 1'b0;
    repeat (200) if (o_done !== 1'b1) @(negedge i_core_clk);
    chk({7'h0, o_done}, 8'h01);
    if (o_done !== 1'b1) tally_and_finish();
  endtask
  task automatic t_id(input logic [1:0] o);
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      e = i == 0 ? dev.MAKER_CODE : i == 1 ? dev.PART_CODE : 8'(i == 3);
      run(o, i == 3 ? 22'h0c0002 : 22'(i));
      chk(o_rdata, e);
      chk({6'h0, o_parity_ok, o_time_limit}, {6'h0, ^e, e[5]});
    end
    $display("identification op %0d done", o);
  endtask
  task automatic t_cmds();
    run(2'h3, 22'h0c123c);
    chk({5'h0, dev.refused, dev.unprot, dev.id_mode}, 8'h02);
    chk({7'h0, o_reset_hv}, 8'h00);
    run(2'h0, 22'h0);
    chk(o_rdata, dev.MAKER_CODE);
    run(2'h2, 22'h3fffff);
    chk({7'h0, dev.id_mode}, 8'h00);
    $display("command test done");
  endtask
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_id(2'h1);
    t_id(2'h0);
    t_cmds();
    tally_and_finish();
  end
endmodule
